// [src/fpd_defs.vh]
// fpd_defs.vh: offsets, field positions, reset values and timing counts
// assumes a 100 MHz clock and an 8-bit register port
`ifndef FPD_DEFS_VH
`define FPD_DEFS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define FPD_OFF_DUTY1      8'h30
`define FPD_OFF_DUTY2      8'h31
`define FPD_OFF_DUTY3      8'h32
`define FPD_OFF_CFG1       8'h5C
`define FPD_OFF_CFG2       8'h5D
`define FPD_OFF_CFG3       8'h5E
`define FPD_OFF_FREQ1      8'h5F
`define FPD_OFF_FREQ2      8'h60
`define FPD_OFF_FREQ3      8'h61

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define FPD_CFG_SPIN_LSB   0
`define FPD_CFG_SPIN_MSB   2
`define FPD_CFG_POL_BIT    4
`define FPD_CFG_BHV_LSB    5
`define FPD_CFG_BHV_MSB    7
`define FPD_FRQ_SEL_LSB    0
`define FPD_FRQ_SEL_MSB    2
`define FPD_FRQ_HF_BIT     3

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FPD_RST_DUTY       8'hFF
`define FPD_RST_CFG        8'h82
`define FPD_RST_LOW_RATE_SELECT       8'h04

// ------------------------------------------------------------
// behaviour codes
// ------------------------------------------------------------
`define FPD_BHV_REM1       3'h0
`define FPD_BHV_LOCAL      3'h1
`define FPD_BHV_REM2       3'h2
`define FPD_BHV_FULL       3'h3
`define FPD_BHV_OFF        3'h4
`define FPD_BHV_LR2        3'h5
`define FPD_BHV_ALL        3'h6
`define FPD_BHV_MANUAL     3'h7

// ------------------------------------------------------------
// timing: clock rate, 1 ms tick, pwm step rates
// ------------------------------------------------------------
`define FPD_CLK_HZ         100000000
`define FPD_MS_CYC         (`FPD_CLK_HZ / 1000)
// high rate: 22.5 kHz, 256 steps a period, rounded down
`define FPD_HF_HZ          22500
`define FPD_HF_STEP        (`FPD_CLK_HZ / (`FPD_HF_HZ * 256))
// low rates in tenths of Hz
`define FPD_LF_DHZ0        110
`define FPD_LF_DHZ1        147
`define FPD_LF_DHZ2        221
`define FPD_LF_DHZ3        294
`define FPD_LF_DHZ4        353
`define FPD_LF_DHZ5        441
`define FPD_LF_DHZ6        588
`define FPD_LF_DHZ7        882
// startup timeouts in ms
`define FPD_TO_MS1         13'd100
`define FPD_TO_MS2         13'd250
`define FPD_TO_MS3         13'd400
`define FPD_TO_MS4         13'd667
`define FPD_TO_MS5         13'd1000
`define FPD_TO_MS6         13'd2000
`define FPD_TO_MS7         13'd4000

`endif

// [src/fpd_channel.v]
// fpd_channel.v: one drive channel, pwm counter, spin-up and timeout
// assumes a 1 ms tick and a one-cycle fan_speed_pulse pulse from the parent
`timescale 1ns/1ps
`include "fpd_defs.vh"

module fpd_channel #(
   parameter MS_CYC = `FPD_MS_CYC
) (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // configuration
   input  wire [7:0] cfg,
   input  wire [7:0] low_rate_select,
   input  wire       spin_fan_speed_pulse_off,
   input  wire [7:0] run_duty,
   input  wire       ms_tick,
   input  wire       fan_speed_pulse_pulse,
   // results
   output reg        drive,
   output reg  [7:0] duty_now,
   output reg        fault,
   output wire       cont_fan_speed_pulse
);

   localparam ST_IDLE = 3'b001;
   localparam ST_SPIN = 3'b010;
   localparam ST_RUN  = 3'b100;

   // ------------------------------------------------------------
   // decoders
   // ------------------------------------------------------------
   function [31:0] step_cyc;
      input [2:0] sel;
      begin
         case (sel)
            3'd0: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ0 * 256);
            3'd1: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ1 * 256);
            3'd2: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ2 * 256);
            3'd3: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ3 * 256);
            3'd4: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ4 * 256);
            3'd5: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ5 * 256);
            3'd6: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ6 * 256);
            default: step_cyc = `FPD_CLK_HZ * 10 / (`FPD_LF_DHZ7 * 256);
         endcase
      end
   endfunction

   function [12:0] timeout_ms;
      input [2:0] sel;
      begin
         case (sel)
            3'd1: timeout_ms = `FPD_TO_MS1;
            3'd2: timeout_ms = `FPD_TO_MS2;
            3'd3: timeout_ms = `FPD_TO_MS3;
            3'd4: timeout_ms = `FPD_TO_MS4;
            3'd5: timeout_ms = `FPD_TO_MS5;
            3'd6: timeout_ms = `FPD_TO_MS6;
            3'd7: timeout_ms = `FPD_TO_MS7;
            default: timeout_ms = 13'd0;
         endcase
      end
   endfunction

   wire        hf_mode = low_rate_select[`FPD_FRQ_HF_BIT];
   wire [2:0]  spin_sel = cfg[`FPD_CFG_SPIN_MSB:`FPD_CFG_SPIN_LSB];
   wire [2:0]  bhv = cfg[`FPD_CFG_BHV_MSB:`FPD_CFG_BHV_LSB];
   wire [31:0] step_lim = hf_mode ? `FPD_HF_STEP :
                          step_cyc(low_rate_select[`FPD_FRQ_SEL_MSB:`FPD_FRQ_SEL_LSB]);
   wire [12:0] to_lim = timeout_ms(spin_sel);

   // dc behaviour forced while high rate runs
   assign cont_fan_speed_pulse = hf_mode;

   // ------------------------------------------------------------
   // free-running step and phase counters
   // ------------------------------------------------------------
   reg [31:0] step_cnt;
   reg [7:0]  phase;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         step_cnt <= 32'h0;
         phase    <= 8'h00;
      end else if (step_cnt + 32'h1 >= step_lim) begin
         step_cnt <= 32'h0;
         phase    <= phase + 8'h01;
      end else begin
         step_cnt <= step_cnt + 32'h1;
      end
   end

   // ------------------------------------------------------------
   // spin-up state machine
   // ------------------------------------------------------------
   reg [2:0]  state;
   reg [12:0] ms_cnt;
   reg [1:0]  fan_speed_pulse_cnt;
   wire       want_on = (run_duty != 8'h00);
   wire       to_hit = (to_lim != 13'd0) && ms_tick && (ms_cnt + 13'd1 >= to_lim);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state    <= ST_IDLE;
         ms_cnt   <= 13'd0;
         fan_speed_pulse_cnt <= 2'd0;
         fault    <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               ms_cnt   <= 13'd0;
               fan_speed_pulse_cnt <= 2'd0;
               if (want_on && bhv != `FPD_BHV_OFF)
                  state <= ST_SPIN;
            end
            ST_SPIN: begin
               if (ms_tick)
                  ms_cnt <= ms_cnt + 13'd1;
               if (fan_speed_pulse_pulse && fan_speed_pulse_cnt != 2'd2)
                  fan_speed_pulse_cnt <= fan_speed_pulse_cnt + 2'd1;
               if (spin_fan_speed_pulse_off) begin
                  if (to_hit || to_lim == 13'd0)
                     state <= ST_RUN;
               end else if (fan_speed_pulse_cnt == 2'd2) begin
                  state <= ST_RUN;
               end else if (to_hit) begin
                  fault <= 1'b1;
                  state <= ST_RUN;
               end
            end
            ST_RUN: begin
               if (!want_on || bhv == `FPD_BHV_OFF)
                  state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
         if (state == ST_IDLE && want_on)
            fault <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   reg [7:0] next_duty;
   always @* begin
      if (state == ST_SPIN)
         next_duty = 8'hFF;
      else if (state == ST_RUN)
         next_duty = run_duty;
      else
         next_duty = 8'h00;
   end

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         duty_now <= `FPD_RST_DUTY;
         drive    <= 1'b1;
      end else begin
         duty_now <= next_duty;
         // 0xFF holds the line on, 0x00 off, else compare
         drive <= ((duty_now == 8'hFF) || (phase < duty_now))
                  ^ cfg[`FPD_CFG_POL_BIT];
      end
   end

endmodule

// [src/fpd_top.v]
// fpd_top.v: three-channel fan drive with its register port
// assumes single-cycle register strobes and synchronous inputs
//
// Behaviour
// - three-bit timeout field: none,100,250,400,667ms,1,2,4s; default 250ms.
// - spin-up disable bit set stops waiting for two fan_speed_pulse pulses.
// - with fan_speed_pulse spin-up off, spin up until the selected number of 1 ms ticks has passed.
// - polarity bit 0 makes full duty high, 1 makes it low.
// - low-rate field selects 11.0 to 88.2 Hz, default 35.3 Hz.
// - frequency register bit 3 selects high-rate drive.
// - high-rate drive is fixed at 22.5 kHz; the code steps every 17 clocks of 100 MHz, about 22.98 kHz.
// - high-rate drive forces continuous fan_speed_pulse behaviour internally.
// - in manual mode the written duty register drives the output.
// - duty is 8 bits, linear 0 to 100 percent.
// - the three duty registers reset to 0xFF.
// - reading duty returns the duty really driven.
// - manual mode plus thermal limit forces full duty.
// - automatic duty ramps from minimum to full over the span.
// - automatic mode follows temperature with no host action.
// - behaviour codes map to sources, full, disabled, fastest, manual.
// - spin-up drives full duty until two fan_speed_pulse pulses, then runs.
// - no two fan_speed_pulse pulses within timeout raises a fan fault.
`timescale 1ns/1ps
`include "fpd_defs.vh"

module fpd_top #(
   parameter MS_CYC = `FPD_MS_CYC
) (
   // clock and reset
   input  wire        clk,
   input  wire        nrst,
   // register port
   input  wire [7:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   // global control
   input  wire        fan_speed_pulse_spinup_disable,
   input  wire        thermal_limit_signal,
   // temperatures: remote 1, local, remote 2
   input  wire [7:0]  temp_rem1,
   input  wire [7:0]  temp_local,
   input  wire [7:0]  temp_rem2,
   input  wire [7:0]  turn_on_threshold_1,
   input  wire [7:0]  turn_on_threshold_2,
   input  wire [7:0]  turn_on_threshold_3,
   input  wire [7:0]  ramp_span_1,
   input  wire [7:0]  ramp_span_2,
   input  wire [7:0]  ramp_span_3,
   input  wire [23:0] minimum_duty,
   // fans
   input  wire [2:0]  fan_speed_pulse,
   output wire        drive_output_1,
   output wire        drive_output_2,
   output wire        drive_output_3,
   output wire [2:0]  fan_fault,
   output wire [2:0]  cont_fan_speed_pulse
);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   reg  [7:0]  duty_reg [0:2];
   reg  [7:0]  cfg_reg  [0:2];
   reg  [7:0]  low_rate_select_reg [0:2];
   wire [7:0]  duty_now [0:2];
   wire [2:0]  drive;
   reg  [2:0]  fan_speed_pulse_q;

   function [1:0] chan_of;
      input [7:0] a;
      input [7:0] base;
      begin
         if (a == base)
            chan_of = 2'd0;
         else if (a == base + 8'h01)
            chan_of = 2'd1;
         else if (a == base + 8'h02)
            chan_of = 2'd2;
         else
            chan_of = 2'd3;
      end
   endfunction

   wire [1:0] duty_ch = chan_of(reg_addr, `FPD_OFF_DUTY1);
   wire [1:0] cfg_ch  = chan_of(reg_addr, `FPD_OFF_CFG1);
   wire [1:0] low_rate_select_ch = chan_of(reg_addr, `FPD_OFF_FREQ1);

   integer i;
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (i = 0; i < 3; i = i + 1) begin
            duty_reg[i] <= `FPD_RST_DUTY;
            cfg_reg[i]  <= `FPD_RST_CFG;
            low_rate_select_reg[i] <= `FPD_RST_LOW_RATE_SELECT;
         end
      end else if (reg_wr) begin
         if (duty_ch != 2'd3 &&
             cfg_reg[duty_ch][`FPD_CFG_BHV_MSB:`FPD_CFG_BHV_LSB]
             == `FPD_BHV_MANUAL)
            duty_reg[duty_ch] <= reg_wdata;
         if (cfg_ch != 2'd3)
            cfg_reg[cfg_ch] <= reg_wdata;
         if (low_rate_select_ch != 2'd3)
            low_rate_select_reg[low_rate_select_ch] <= {4'h0, reg_wdata[3:0]};
      end
   end

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always @(posedge clk or negedge nrst) begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         if (duty_ch != 2'd3)
            reg_rdata <= duty_now[duty_ch];
         else if (cfg_ch != 2'd3)
            reg_rdata <= cfg_reg[cfg_ch];
         else if (low_rate_select_ch != 2'd3)
            reg_rdata <= low_rate_select_reg[low_rate_select_ch];
         else
            reg_rdata <= 8'h00;
      end
   end

   // ------------------------------------------------------------
   // millisecond tick and fan_speed_pulse edge
   // ------------------------------------------------------------
   reg [31:0] ms_cnt;
   wire       ms_tick = (ms_cnt + 32'h1 >= MS_CYC);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ms_cnt <= 32'h0;
         // fan_speed_pulse lines idle at their pull-up level, so no false edge
         fan_speed_pulse_q <= 3'b111;
      end else begin
         ms_cnt <= ms_tick ? 32'h0 : ms_cnt + 32'h1;
         fan_speed_pulse_q <= fan_speed_pulse;
      end
   end
   wire [2:0] fan_speed_pulse_rise = fan_speed_pulse & ~fan_speed_pulse_q;

   // ------------------------------------------------------------
   // automatic duty per temperature source
   // ------------------------------------------------------------
   function [7:0] ramp;
      input [7:0] t;
      input [7:0] turn_on_threshold;
      input [7:0] span;
      input [7:0] dmin;
      reg   [8:0] over;
      reg   [16:0] lift;
      begin
         over = {1'b0, t} - {1'b0, turn_on_threshold};
         lift = 17'h0;
         if (t < turn_on_threshold)
            ramp = 8'h00;
         else if (span == 8'h00 || over[7:0] >= span)
            ramp = 8'hFF;
         else begin
            lift = ({9'h0, 8'hFF - dmin} * {9'h0, over[7:0]}) / {9'h0, span};
            ramp = dmin + lift[7:0];
         end
      end
   endfunction

   function [7:0] max2;
      input [7:0] a;
      input [7:0] b;
      begin
         max2 = (a > b) ? a : b;
      end
   endfunction

   wire [7:0] auto_r1 = ramp(temp_rem1,  turn_on_threshold_1, ramp_span_1,
                             minimum_duty[7:0]);
   wire [7:0] auto_lc = ramp(temp_local, turn_on_threshold_2, ramp_span_2,
                             minimum_duty[15:8]);
   wire [7:0] auto_r2 = ramp(temp_rem2,  turn_on_threshold_3, ramp_span_3,
                             minimum_duty[23:16]);

   // ------------------------------------------------------------
   // channels
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : chan
         reg [7:0] run_duty;
         always @* begin
            case (cfg_reg[g][`FPD_CFG_BHV_MSB:`FPD_CFG_BHV_LSB])
               `FPD_BHV_REM1:   run_duty = auto_r1;
               `FPD_BHV_LOCAL:  run_duty = auto_lc;
               `FPD_BHV_REM2:   run_duty = auto_r2;
               `FPD_BHV_FULL:   run_duty = 8'hFF;
               `FPD_BHV_LR2:    run_duty = max2(auto_lc, auto_r2);
               `FPD_BHV_ALL:    run_duty = max2(auto_r1,
                                                max2(auto_lc, auto_r2));
               `FPD_BHV_MANUAL: run_duty = thermal_limit_signal ? 8'hFF
                                           : duty_reg[g];
               default:         run_duty = 8'h00;
            endcase
         end

         fpd_channel #(
            .MS_CYC        (MS_CYC)
         ) u_chan (
            .clk           (clk),
            .nrst          (nrst),
            .cfg           (cfg_reg[g]),
            .low_rate_select          (low_rate_select_reg[g]),
            .spin_fan_speed_pulse_off (fan_speed_pulse_spinup_disable),
            .run_duty      (run_duty),
            .ms_tick       (ms_tick),
            .fan_speed_pulse_pulse    (fan_speed_pulse_rise[g]),
            .drive         (drive[g]),
            .duty_now      (duty_now[g]),
            .fault         (fan_fault[g]),
            .cont_fan_speed_pulse     (cont_fan_speed_pulse[g])
         );
      end
   endgenerate

   assign drive_output_1 = drive[0];
   assign drive_output_2 = drive[1];
   assign drive_output_3 = drive[2];

endmodule

// [testbench/fpd_top_sva.sv]
// fpd_top_sva.sv: assertions on the fan drive register port and outputs
// assumes a bind to fpd_top; sees only its ports
`timescale 1ns/1ps

module fpd_top_sva (
   // clock and reset
   input wire       clk,
   input wire       nrst,
   // register port
   input wire [7:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   // fan side
   input wire       thermal_limit_signal,
   input wire       drive_output_1,
   input wire [2:0] cont_fan_speed_pulse
);
   reg  [7:0] cfg1;
   reg  [3:0] full_cnt;
   wire       mapped;

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   // ------------------------------------------------------------
   // shadow of channel 1 configuration
   // ------------------------------------------------------------
   assign mapped = (reg_addr >= 8'h30 && reg_addr <= 8'h32) ||
                   (reg_addr >= 8'h5C && reg_addr <= 8'h61);

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg1     <= 8'h82;
         full_cnt <= 4'h0;
      end else if (reg_wr && reg_addr == 8'h5C) begin
         cfg1     <= reg_wdata;
         full_cnt <= 4'h0;
      end else if (cfg1[7:5] == 3'h3 && full_cnt != 4'hF) begin
         full_cnt <= full_cnt + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   AST_UNMAPPED_ZERO: assert property (
      reg_rd && !mapped |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   AST_LOW_RATE_SELECT_HIGH_ZERO: assert property (
      reg_rd && reg_addr >= 8'h5F && reg_addr <= 8'h61
      |=> reg_rdata[7:4] == 4'h0)
      else $error("frequency upper bits not zero");
   AST_CONT_FAN_SPEED_PULSE: assert property (
      reg_wr && reg_addr == 8'h5F |=> cont_fan_speed_pulse[0] == $past(reg_wdata[3]))
      else $error("continuous fan_speed_pulse does not follow high rate bit");
   AST_CFG_READBACK: assert property (
      reg_wr && reg_addr == 8'h5C ##1 !reg_wr ##1 reg_rd &&
      reg_addr == 8'h5C |=> reg_rdata == $past(reg_wdata, 3))
      else $error("configuration readback differs");
   AST_RDATA_HOLD: assert property (
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");
   AST_THERMAL_LIMIT_SIGNAL_FULL: assert property (
      thermal_limit_signal [*4] ##0 (cfg1[7:5] == 3'h7 && reg_rd &&
      reg_addr == 8'h30) |=> reg_rdata == 8'hFF)
      else $error("thermal limit did not force full duty");
   AST_FULL_READ: assert property (
      full_cnt >= 4'h8 && reg_rd && reg_addr == 8'h30
      |=> reg_rdata == 8'hFF)
      else $error("full speed duty not read as full");
   AST_POLARITY: assert property (
      full_cnt >= 4'h8 |-> drive_output_1 == !cfg1[4])
      else $error("full duty level does not follow polarity");
endmodule

// [testbench/fpd_fan_model.sv]
// fpd_fan_model.sv: three fans giving one fan_speed_pulse pulse every 64 clocks
// assumes pulled-up fan_speed_pulse lines; a stalled fan gives no edges
`timescale 1ns/1ps

module fpd_fan_model (
   // clock and reset
   input  wire       clk,
   input  wire       nrst,
   // fan control and fan_speed_pulse
   input  wire [2:0] stall,
   output reg  [2:0] pulse
);
   reg [5:0] phase;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         phase <= 6'h00;
         pulse <= 3'h7;
      end else begin
         phase <= phase + 6'h01;
         // a stalled fan leaves its line at the pull-up level
         pulse <= stall | {3{phase < 6'h20}};
      end
   end
endmodule

// [testbench/fpd_top_test.sv]
// fpd_top_test.sv: register-level test of the three-channel fan drive
// assumes fpd_top, the fan model and the checker compiled before it
`timescale 1ns/1ps
`include "fpd_defs.vh"

module fpd_top_test;
   reg         clk;
   reg         nrst;
   reg  [7:0]  reg_addr;
   reg         reg_wr;
   reg         reg_rd;
   reg  [7:0]  reg_wdata;
   wire [7:0]  reg_rdata;
   reg         fan_speed_pulse_spinup_disable;
   reg         thermal_limit_signal;
   reg  [7:0]  temp_rem1;
   reg  [7:0]  temp_local;
   reg  [7:0]  temp_rem2;
   reg  [7:0]  thr;
   reg  [7:0]  span;
   reg  [23:0] minimum_duty;
   reg  [2:0]  stall;
   wire [2:0]  fan_speed_pulse;
   wire [2:0]  fan_fault;
   wire [2:0]  cont_fan_speed_pulse;
   wire [2:0]  drv;
   reg  [55:0] tbl;
   integer     num_errors;
   integer     checks;
   integer     cyc;
   integer     i;
   integer     hi;
   integer     lo;

   fpd_top #(.MS_CYC(10)) u_fpd_top (
      .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .fan_speed_pulse_spinup_disable(fan_speed_pulse_spinup_disable),
      .thermal_limit_signal(thermal_limit_signal),
      .temp_rem1(temp_rem1), .temp_local(temp_local),
      .temp_rem2(temp_rem2), .turn_on_threshold_1(thr),
      .turn_on_threshold_2(thr), .turn_on_threshold_3(thr),
      .ramp_span_1(span), .ramp_span_2(span), .ramp_span_3(span),
      .minimum_duty(minimum_duty), .fan_speed_pulse(fan_speed_pulse),
      .drive_output_1(drv[0]), .drive_output_2(drv[1]),
      .drive_output_3(drv[2]), .fan_fault(fan_fault),
      .cont_fan_speed_pulse(cont_fan_speed_pulse));

   fpd_fan_model u_fpd_fan_model (
      .clk(clk), .nrst(nrst), .stall(stall), .pulse(fan_speed_pulse));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         num_errors = num_errors + 1;
         end_of_test;
      end
   end

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task check(input string nm, input [15:0] seen, input [15:0] exp);
      begin
         checks = checks + 1;
         if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask

   task wr(input [7:0] a, input [7:0] d);
      begin
         @(posedge clk);
         reg_addr  <= a;
         reg_wdata <= d;
         reg_wr    <= 1'b1;
         @(posedge clk);
         reg_wr    <= 1'b0;
      end
   endtask

   task rd(input [7:0] a, input [7:0] e, input string nm);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd   <= 1'b1;
         @(posedge clk);
         reg_rd   <= 1'b0;
         @(posedge clk);
         @(negedge clk);
         check(nm, {8'h00, reg_rdata}, {8'h00, e});
      end
   endtask

   task waitc(input integer k);
      begin
         repeat (k) @(posedge clk);
         @(negedge clk);
      end
   endtask

   task lvl(input v, output integer c);
      begin
         c = 0;
         while (drv[0] !== v && c < 9000) begin
            @(negedge clk);
            c = c + 1;
         end
      end
   endtask

   task end_of_test;
      begin
         $display("errors %0d checks %0d", num_errors, checks);
         if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask

   // ------------------------------------------------------------
   // test sequence
   // ------------------------------------------------------------
   initial begin
      num_errors = 0;
      checks = 0;
      cyc = 0;
      nrst = 1'b0;
      reg_addr = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      fan_speed_pulse_spinup_disable = 1'b0;
      thermal_limit_signal = 1'b0;
      temp_rem1 = 8'h5E;
      temp_local = 8'h54;
      temp_rem2 = 8'h5C;
      thr = 8'h50;
      span = 8'h10;
      minimum_duty = 24'h3F3F3F;
      stall = 3'b100;
      tbl = 56'hE76FCFFF00CFE7;
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      rd(8'h5C, 8'h82, "cfg1 reset");
      rd(8'h5F, 8'h04, "freq1 reset");
      rd(8'h40, 8'h00, "unmapped");
      wr(8'h5F, 8'hFC);
      rd(8'h5F, 8'h0C, "freq1 high rate");
      check("cont_fan_speed_pulse", {13'h0, cont_fan_speed_pulse}, 16'h0001);
      wr(8'h5C, 8'hE2);
      waitc(300);
      rd(8'h30, 8'hFF, "duty1 reset");
      wr(8'h30, 8'h80);
      rd(8'h30, 8'h80, "duty1 manual");
      lvl(1'b0, lo);
      lvl(1'b1, lo);
      lvl(1'b0, hi);
      lvl(1'b1, lo);
      lo = hi + lo;
      check("hf period", lo[15:0], 16'(256 * `FPD_HF_STEP));
      check("hf high", hi[15:0], 16'(128 * `FPD_HF_STEP));
      wr(8'h30, 8'h40);
      thermal_limit_signal <= 1'b1;
      waitc(8);
      rd(8'h30, 8'hFF, "duty1 thermal");
      @(posedge clk);
      thermal_limit_signal <= 1'b0;
      waitc(8);
      rd(8'h30, 8'h40, "duty1 driven");
      wr(8'h5C, 8'h62);
      waitc(10);
      check("drive1 full", {15'h0, drv[0]}, 16'h0001);
      wr(8'h5C, 8'h72);
      rd(8'h5C, 8'h72, "cfg1 readback");
      waitc(10);
      check("drive1 inverted", {15'h0, drv[0]}, 16'h0000);
      rd(8'h30, 8'hFF, "duty1 full");
      @(posedge clk);
      fan_speed_pulse_spinup_disable <= 1'b1;
      stall <= 3'b110;
      wr(8'h5D, 8'hE1);
      wr(8'h31, 8'h40);
      waitc(800);
      rd(8'h31, 8'hFF, "duty2 fixed spin");
      check("drive2 spin", {15'h0, drv[1]}, 16'h0001);
      waitc(300);
      rd(8'h31, 8'h40, "duty2 after spin");
      @(posedge clk);
      fan_speed_pulse_spinup_disable <= 1'b0;
      stall <= 3'b100;
      wr(8'h5E, 8'hE3);
      waitc(3880);
      check("fault3 early", {13'h0, fan_fault}, 16'h0000);
      waitc(200);
      check("fault3", {13'h0, fan_fault}, 16'h0004);
      rd(8'h32, 8'hFF, "duty3 after fault");
      check("drive3 full", {15'h0, drv[2]}, 16'h0001);
      for (i = 0; i < 7; i = i + 1) begin
         wr(8'h5D, {i[2:0], 5'h02});
         waitc(300);
         rd(8'h31, tbl[8 * (6 - i) +: 8], "duty2 auto");
      end
      wr(8'h31, 8'h00);
      rd(8'h31, 8'hE7, "duty2 refused");
      wr(8'h5D, 8'hE2);
      rd(8'h31, 8'h40, "duty2 kept");
      end_of_test;
   end
endmodule

bind fpd_top fpd_top_sva u_fpd_top_sva (
   .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .thermal_limit_signal(thermal_limit_signal),
   .drive_output_1(drive_output_1), .cont_fan_speed_pulse(cont_fan_speed_pulse));
